// ===== core/csc_channel.sv
// clocked serial channel, master receive and full duplex
// assumes control bits as plain ports, pins synchronous to i_clk domain
`timescale 1ns/10ps
`include "csc_consts.svh"
module csc_channel #(
    parameter int PRESCALE_W = `CSC_PRESCALE_W,
    parameter int BAUD_W     = `CSC_BAUD_W,
    parameter int FIFO_DEPTH = `CSC_FIFO_DEPTH
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_start_trigger_bit,
    input  wire logic                  i_stop_trigger_bit,
    input  wire logic                  i_flag_clear_overrun,
    input  wire logic                  i_output_enable_bit,
    input  wire logic                  i_clock_idle_level,
    input  wire logic                  i_data_idle_level,
    input  wire logic                  i_idle_level_wr,
    input  wire logic [PRESCALE_W-1:0] i_prescaler_select_reg,
    input  wire logic [BAUD_W-1:0]     i_baud_div,
    input  wire logic                  i_interrupt_timing_bit,
    input  wire logic                  i_data_phase_bit,
    input  wire logic                  i_clock_polarity_bit,
    input  wire logic                  i_frame_len8,
    input  wire logic                  i_lsb_first,
    input  wire logic                  i_tx_enable,
    input  wire logic                  i_rx_enable,
    input  wire logic                  i_data_wr,
    input  wire logic [7:0]            i_data_reg_low_byte,
    input  wire logic                  i_data_rd,
    input  wire logic                  i_serial_input_line,
    output logic                       o_serial_clock_line,
    output logic                       o_serial_output_line,
    output logic                       o_serial_clock_oe,
    output logic                       o_serial_output_oe,
    output logic                       o_channel_interrupt,
    output logic                       o_channel_enabled_status,
    output logic                       o_buffer_full_flag,
    output logic                       o_overrun_flag,
    output logic                       o_busy,
    output logic [7:0]                 o_rx_data
);
    import csc_pkg::*;

    // ========================================================
    // input synchronisers
    logic si_meta_reg;
    logic si_sync_reg;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            si_meta_reg <= 1'b0;
            si_sync_reg <= 1'b0;
        end else begin
            si_meta_reg <= i_serial_input_line;
            si_sync_reg <= si_meta_reg;
        end
    end

    // ========================================================
    // operation clock and baud tick
    // prescaler: operation clock tick every 2^sel system clocks
    logic [15:0]       pre_cnt_reg;
    logic [BAUD_W-1:0] baud_cnt_reg;
    wire [15:0] pre_mask = 16'((32'h1 << i_prescaler_select_reg) - 1);
    wire        mck_tick = ((pre_cnt_reg & pre_mask) == pre_mask);
    // half period = baud_div+1 mck ticks, so max rate is mck/2
    wire        half_tick = mck_tick && (baud_cnt_reg == i_baud_div);
    logic       run_reg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pre_cnt_reg  <= 16'h0000;
            baud_cnt_reg <= '0;
        end else if (!run_reg) begin
            pre_cnt_reg  <= 16'h0000;
            baud_cnt_reg <= '0;
        end else begin
            pre_cnt_reg <= 16'(pre_cnt_reg + 1'b1);
            if (half_tick) baud_cnt_reg <= '0;
            else if (mck_tick) baud_cnt_reg <= BAUD_W'(baud_cnt_reg + 1'b1);
        end
    end

    // ========================================================
    // enable, start and stop
    logic enabled_reg;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) enabled_reg <= 1'b0;
        else if (i_stop_trigger_bit) enabled_reg <= 1'b0;
        else if (i_start_trigger_bit) enabled_reg <= 1'b1;
    end

    // ========================================================
    // transmit buffer and shift engine
    csc_state_t  state_reg;
    logic [7:0]  tx_buf_reg;
    logic        tx_full_reg;
    logic [7:0]  shift_reg;
    logic [3:0]  bit_cnt_reg;
    logic        phase_reg;
    logic        sck_reg;
    logic        sdo_reg;

    wire [3:0] frame_bits = i_frame_len8 ? 4'h8 : 4'h7;
    wire       load_go    = enabled_reg && tx_full_reg &&
                            (state_reg == CSC_IDLE);
    wire       frame_end;
    wire [7:0] load_val   = i_tx_enable ? tx_buf_reg : 8'hFF;
    wire       out_bit    = i_lsb_first ? shift_reg[0] :
                            (i_frame_len8 ? shift_reg[7] : shift_reg[6]);
    wire [7:0] shift_in_msb = i_frame_len8 ? {shift_reg[6:0], si_sync_reg}
                            : {1'b0, shift_reg[5:0], si_sync_reg};
    wire [7:0] shift_in_lsb = i_frame_len8 ? {si_sync_reg, shift_reg[7:1]}
                            : {1'b0, si_sync_reg, shift_reg[6:1]};
    wire [7:0] shift_in   = i_lsb_first ? shift_in_lsb : shift_in_msb;
    wire       last_bit   = (bit_cnt_reg == frame_bits - 4'h1);

    // sample closes half 1, or half 0 when data leads by half a cell
    wire       sample_edge = half_tick && (phase_reg ^ i_data_phase_bit);
    assign frame_end = (state_reg == CSC_SHIFT) && sample_edge && last_bit;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) tx_full_reg <= 1'b0;
        else if (!enabled_reg) tx_full_reg <= 1'b0;
        else if (i_data_wr) tx_full_reg <= 1'b1;
        else if (load_go) tx_full_reg <= 1'b0;
    end

    always_ff @(posedge i_clk) begin
        if (i_data_wr) tx_buf_reg <= i_data_reg_low_byte;
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg   <= CSC_IDLE;
            bit_cnt_reg <= 4'h0;
            phase_reg   <= 1'b0;
            shift_reg   <= 8'h00;
            run_reg     <= 1'b0;
        end else if (!enabled_reg) begin
            state_reg <= CSC_IDLE;
            run_reg   <= 1'b0;
        end else begin
            case (state_reg)
                CSC_IDLE: begin
                    if (load_go) begin
                        shift_reg   <= load_val;
                        bit_cnt_reg <= 4'h0;
                        phase_reg   <= 1'b0;
                        run_reg     <= 1'b1;
                        // phase 1: data leads clock by half period
                        state_reg   <= i_data_phase_bit ? CSC_LEAD : CSC_SHIFT;
                    end
                end
                CSC_LEAD: begin
                    if (half_tick) state_reg <= CSC_SHIFT;
                end
                CSC_SHIFT: begin
                    if (half_tick) begin
                        phase_reg <= ~phase_reg;
                        if (sample_edge) begin
                            shift_reg <= shift_in;
                            if (last_bit) begin
                                state_reg <= CSC_IDLE;
                                run_reg   <= 1'b0;
                            end else begin
                                bit_cnt_reg <= 4'(bit_cnt_reg + 1'b1);
                            end
                        end
                    end
                end
                default: state_reg <= CSC_IDLE;
            endcase
        end
    end

    // ========================================================
    // pins: idle levels, polarity, output enable
    logic idle_clk_reg;
    logic idle_data_reg;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            idle_clk_reg  <= `CSC_IDLE_CLK_RST;
            idle_data_reg <= `CSC_IDLE_DATA_RST;
        end else if (i_idle_level_wr && !run_reg) begin
            idle_clk_reg  <= i_clock_idle_level;
            idle_data_reg <= i_data_idle_level;
        end
    end

    wire active = (state_reg == CSC_SHIFT);
    // clock low-going in first half cell when polarity 0
    wire sck_drive = active ? (phase_reg ^ i_clock_polarity_bit)
                            : idle_clk_reg;
    wire sdo_next = (state_reg != CSC_IDLE && i_tx_enable) ? out_bit
                                                           : idle_data_reg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sck_reg <= `CSC_IDLE_CLK_RST;
            sdo_reg <= `CSC_IDLE_DATA_RST;
        end else begin
            sck_reg <= sck_drive;
            sdo_reg <= sdo_next;
        end
    end

    logic oe_clk_reg;
    logic oe_sdo_reg;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            oe_clk_reg <= 1'b0;
            oe_sdo_reg <= 1'b0;
        end else begin
            oe_clk_reg <= i_output_enable_bit;
            oe_sdo_reg <= i_output_enable_bit && i_tx_enable;
        end
    end

    // ========================================================
    // receive fifo, buffer full and overrun
    logic       fifo_ready;
    logic       fifo_valid;
    logic [7:0] fifo_data;
    wire        rx_push = frame_end && i_rx_enable;
    wire        rx_pop  = i_data_rd && fifo_valid;

    csc_fifo #(
        .WIDTH (`CSC_DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_data  (shift_in),
        .i_valid (rx_push),
        .o_ready (fifo_ready),
        .o_data  (fifo_data),
        .o_valid (fifo_valid),
        .i_ready (rx_pop),
        .i_flush (i_stop_trigger_bit)
    );

    logic ovf_reg;
    logic bff_reg;
    logic irq_reg;
    logic [7:0] rx_data_reg;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ovf_reg     <= 1'b0;
            bff_reg     <= 1'b0;
            irq_reg     <= 1'b0;
            rx_data_reg <= 8'h00;
        end else begin
            // set wins over clear; only overrun is flagged
            if (rx_push && !fifo_ready) ovf_reg <= 1'b1;
            else if (i_flag_clear_overrun) ovf_reg <= 1'b0;
            // one cycle behind the fifo, in step with the read data
            bff_reg     <= fifo_valid;
            rx_data_reg <= fifo_data;
            // mode read live so mid-run changes apply
            irq_reg <= i_interrupt_timing_bit ? load_go : frame_end;
        end
    end

    assign o_serial_clock_line      = sck_reg;
    assign o_serial_output_line     = sdo_reg;
    assign o_serial_clock_oe        = oe_clk_reg;
    assign o_serial_output_oe       = oe_sdo_reg;
    assign o_channel_interrupt      = irq_reg;
    assign o_channel_enabled_status = enabled_reg;
    assign o_buffer_full_flag       = bff_reg;
    assign o_overrun_flag           = ovf_reg;
    assign o_busy                   = run_reg;
    assign o_rx_data                = rx_data_reg;

    // ========================================================
    // checks
    sequence s_start;
        load_go;
    endsequence
    a_start_runs: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_start |=> run_reg)
        else $error("start write did not run clock");
    a_stop_disables: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_stop_trigger_bit |=> !enabled_reg ##1 !run_reg)
        else $error("stop did not disable");
    a_start_enables: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_start_trigger_bit && !i_stop_trigger_bit) |=> enabled_reg)
        else $error("start did not enable");
    a_ovf_sticky: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (ovf_reg && !i_flag_clear_overrun) |=> ovf_reg)
        else $error("overrun cleared without trigger");
    a_ovf_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (rx_push && !fifo_ready) |=> ovf_reg)
        else $error("overrun missed");
    a_irq_end: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (frame_end && !i_interrupt_timing_bit) |=> o_channel_interrupt)
        else $error("end interrupt missing");
    a_irq_empty: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (load_go && i_interrupt_timing_bit) |=> o_channel_interrupt)
        else $error("empty interrupt missing");
    a_idle_clock: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state_reg == CSC_IDLE) [*2] |-> sck_reg == $past(idle_clk_reg))
        else $error("idle clock level wrong");
endmodule // csc_channel

// ===== inc/csc_consts.svh
// constants for the clocked serial channel (master receive / full duplex)
// assumes a single 100 MHz system clock and plain control ports
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH

`define CSC_FRAME_LEN_7     1'b0
`define CSC_FRAME_LEN_8     1'b1
`define CSC_PRESCALE_W      4
`define CSC_BAUD_W          7
`define CSC_DATA_W          8
`define CSC_FIFO_DEPTH      16
`define CSC_IDLE_CLK_RST    1'b1
`define CSC_IDLE_DATA_RST   1'b1

`endif

// ===== inc/csc_pkg.sv
// types for the clocked serial channel
// assumes csc_consts.svh is on the include path
package csc_pkg;
    typedef enum logic [1:0] {
        CSC_IDLE,
        CSC_LEAD,
        CSC_SHIFT
    } csc_state_t;
endpackage

// ===== core/csc_fifo.sv
// parameterised valid/ready fifo for received words
// assumes a single clock domain and active low asynchronous reset
`timescale 1ns/10ps
module csc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic      [WIDTH-1:0] o_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    input  wire logic             i_flush
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push = i_valid && o_ready;
    wire              pop  = o_valid && i_ready;

    assign o_ready = (count_reg != (AW+1)'(DEPTH));
    assign o_valid = (count_reg != '0);
    assign o_data  = mem[rd_ptr_reg];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (i_flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
            if (pop)  rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
            count_reg <= (AW+1)'(count_reg + push - pop);
        end
    end

    a_fifo_no_overflow: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (!o_ready && !pop && !i_flush) |=> !o_ready)
        else $error("fifo pushed while full");
endmodule // csc_fifo

// ===== verification/csc_slave_model.sv
// behavioural serial slave standing on the channel's clock and data lines
// assumes frame settings stay put while a frame is on the wire
`timescale 1ns/10ps
module csc_slave_model (
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_sck,
    input  wire logic       i_mosi,
    input  wire logic       i_dap,
    input  wire logic       i_len8,
    input  wire logic       i_lsb_first,
    input  wire logic [7:0] i_tx_byte,
    output logic            o_miso,
    output logic      [7:0] o_rx_byte
);
    logic sck_reg;
    int   edge_cnt;
    int   idle_cnt;
    int   nbits;
    assign nbits = i_len8 ? 8 : 7;
    // place of frame bit k inside the byte
    function automatic int pos(input int k);
        return i_lsb_first ? k : nbits - 1 - k;
    endfunction
    // ==========================================================
    // edge tracking, sampling and shifting
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sck_reg   <= 1'b1;
            edge_cnt  <= 0;
            idle_cnt  <= 0;
            o_miso    <= 1'b0;
            o_rx_byte <= 8'h00;
        end else begin
            sck_reg <= i_sck;
            if (i_sck !== sck_reg) begin
                idle_cnt <= 0;
                edge_cnt <= (edge_cnt + 1 == 2 * nbits) ? 0 : edge_cnt + 1;
                // lead edges sample when data leads the clock
                if ((edge_cnt % 2 == 0) == i_dap)
                    o_rx_byte[pos(edge_cnt / 2)] <= i_mosi;
                else if (edge_cnt + 1 < 2 * nbits)
                    o_miso <= i_tx_byte[pos((edge_cnt + 1) / 2)];
            end else begin
                idle_cnt <= idle_cnt + 1;
                // long silence: a stray idle flip is no frame
                if (idle_cnt > 40)
                    edge_cnt <= 0;
                // hold over, then no stale bit on the line
                if (idle_cnt > 4 && edge_cnt == 0)
                    o_miso <= i_dap ? i_tx_byte[pos(0)] : ~o_miso;
            end
        end
    end
endmodule // csc_slave_model

// ===== verification/csc_channel_tb.sv
// self-checking bench: table of frames, fill and overrun, overwrite, stop
// assumes csc_slave_model answers on the serial input line
`timescale 1ns/10ps
module csc_channel_tb;
    typedef struct packed {
        logic       dap;
        logic       pol;
        logic       len8;
        logic       lsb;
        logic       txe;
        logic [3:0] sel;
        logic [7:0] tx;
        logic [7:0] sl;
    } csc_row_t;
    logic       i_clk, i_nrst, out_en, clk_idle, dat_idle, timing, txe;
    logic       dap, pol, len8, lsb, wr;
    logic [4:0] trig;
    logic [3:0] sel;
    logic [6:0] baud;
    logic [7:0] wdata, slave_tx, mask, rx_data, slave_rx;
    logic       sck, so, sck_oe, so_oe, irq, en, bff, ovf, busy, miso;
    int         n_fail, check_count, half, waited;
    csc_row_t   rows [6];

    csc_channel uut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_start_trigger_bit(trig[3]),
        .i_stop_trigger_bit(trig[2]), .i_flag_clear_overrun(trig[1]),
        .i_output_enable_bit(out_en), .i_clock_idle_level(clk_idle),
        .i_data_idle_level(dat_idle), .i_idle_level_wr(trig[0]),
        .i_prescaler_select_reg(sel), .i_baud_div(baud),
        .i_interrupt_timing_bit(timing), .i_data_phase_bit(dap),
        .i_clock_polarity_bit(pol), .i_frame_len8(len8),
        .i_lsb_first(lsb), .i_tx_enable(txe), .i_rx_enable(1'b1),
        .i_data_wr(wr), .i_data_reg_low_byte(wdata), .i_data_rd(trig[4]),
        .i_serial_input_line(miso), .o_serial_clock_line(sck),
        .o_serial_output_line(so), .o_serial_clock_oe(sck_oe),
        .o_serial_output_oe(so_oe), .o_channel_interrupt(irq),
        .o_channel_enabled_status(en), .o_buffer_full_flag(bff),
        .o_overrun_flag(ovf), .o_busy(busy), .o_rx_data(rx_data)
    );
    csc_slave_model slave (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_sck(sck), .i_mosi(so),
        .i_dap(dap), .i_len8(len8), .i_lsb_first(lsb),
        .i_tx_byte(slave_tx), .o_miso(miso), .o_rx_byte(slave_rx)
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // ==========================================================
    // shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            n_fail++;
        end
    endtask
    task automatic close_out();
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // gap edge after each pulse so back-to-back calls never collide
    task automatic pulse(input logic [4:0] m);
        @(posedge i_clk) trig <= m;
        @(posedge i_clk) trig <= 5'h00;
        @(posedge i_clk);
    endtask
    task automatic do_write(input logic [7:0] b);
        @(posedge i_clk) begin
            wr    <= 1'b1;
            wdata <= b;
        end
        @(posedge i_clk) wr <= 1'b0;
        @(posedge i_clk);
    endtask
    // waits for the interrupt, measuring the serial half period
    task automatic wait_irq(output int half_out);
        int   t0;
        int   t1;
        logic s;
        waited = 0;
        t0 = -1;
        t1 = -1;
        @(posedge i_clk);
        s = sck;
        while (irq !== 1'b1) begin
            @(posedge i_clk);
            waited++;
            if (sck !== s && t0 >= 0 && t1 < 0)
                t1 = waited;
            if (sck !== s && t0 < 0)
                t0 = waited;
            s = sck;
            if (waited > 5000) begin
                n_fail++;
                close_out();
            end
        end
        half_out = t1 - t0;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rows = '{'{0, 0, 1, 0, 1, 4'h0, 8'hA5, 8'h3C},
                 '{1, 0, 1, 1, 1, 4'h0, 8'h96, 8'hC3},
                 '{0, 1, 0, 0, 1, 4'h1, 8'h5A, 8'h71},
                 '{1, 1, 0, 1, 1, 4'h0, 8'h0F, 8'h4E},
                 '{0, 0, 1, 1, 0, 4'h0, 8'h00, 8'h81},
                 '{1, 1, 1, 0, 1, 4'h1, 8'hFF, 8'h00}};
        n_fail = 0;
        check_count = 0;
        i_nrst = 1'b0;
        {dap, pol, len8, lsb, txe, sel} = 9'h000;
        {trig, wr, timing, wdata, slave_tx} = 23'h000000;
        {out_en, clk_idle, dat_idle} = 3'h7;
        baud = 7'h07;
        tick(15);
        check({6'h00, sck_oe, so_oe}, 8'h00);
        check({6'h00, sck, so}, 8'h03);
        @(posedge i_clk) i_nrst <= 1'b1;
        tick(2);
        check({4'h0, en, bff, ovf, irq}, 8'h00);
        do_write(8'h55);
        tick(4);
        check({7'h00, busy}, 8'h00);
        pulse(5'h08);
        check({7'h00, en}, 8'h01);
        for (int i = 0; i < 6; i++) begin
            @(posedge i_clk) {dap, pol, len8, lsb, txe, sel} <= rows[i][24:16];
            slave_tx <= rows[i].sl;
            clk_idle <= ~rows[i].pol;
            mask = rows[i].len8 ? 8'hFF : 8'h7F;
            pulse(5'h01);
            tick(50);
            do_write(rows[i].tx);
            tick(3);
            if (!rows[i].txe)
                check({7'h00, so_oe}, 8'h00);
            wait_irq(half);
            check(8'(half), 8'(8 << rows[i].sel));
            tick(3);
            check({7'h00, bff}, 8'h01);
            check(rx_data, rows[i].sl & mask);
            if (rows[i].txe)
                check(slave_rx & mask, rows[i].tx & mask);
            check({7'h00, ovf}, 8'h00);
            pulse(5'h10);
            tick(1);
            check({7'h00, bff}, 8'h00);
        end
        // continuous run: 17 frames into a 16 deep buffer
        @(posedge i_clk) {dap, pol, len8, lsb, txe, sel} <= rows[0][24:16];
        slave_tx <= 8'h3C;
        timing <= 1'b1;
        clk_idle <= ~rows[0].pol;
        pulse(5'h01);
        tick(50);
        do_write(8'hFF);
        for (int i = 0; i < 16; i++) begin
            wait_irq(half);
            if (i == 0)
                check({7'h00, waited < 10}, 8'h01);
            if (i == 15)
                timing <= 1'b0;
            do_write(8'hFF);
        end
        wait_irq(half);
        wait_irq(half);
        tick(3);
        check({6'h00, bff, ovf}, 8'h03);
        pulse(5'h02);
        check({7'h00, ovf}, 8'h00);
        for (int i = 0; i < 16; i++) begin
            check(rx_data, 8'h3C);
            pulse(5'h10);
        end
        tick(1);
        check({7'h00, bff}, 8'h00);
        // pending byte overwritten before it loads; timing stays 0
        do_write(8'hA1);
        do_write(8'hB2);
        do_write(8'hC3);
        wait_irq(half);
        wait_irq(half);
        check(slave_rx, 8'hC3);
        pulse(5'h04);
        tick(1);
        check({6'h00, en, bff}, 8'h00);
        @(posedge i_clk) {clk_idle, dat_idle} <= 2'h0;
        pulse(5'h01);
        tick(2);
        check({6'h00, sck, so}, 8'h00);
        check({7'h00, sck_oe}, 8'h01);
        @(posedge i_clk) out_en <= 1'b0;
        tick(3);
        check({6'h00, sck_oe, so_oe}, 8'h00);
        // full initialisation with the channel stopped, as after a gated clock
        @(posedge i_clk) i_nrst <= 1'b0;
        tick(3);
        check({5'h00, sck, so, en}, 8'h06);
        @(posedge i_clk) i_nrst <= 1'b1;
        tick(2);
        check({5'h00, sck_oe, bff, ovf}, 8'h00);
        close_out();
    end
endmodule // csc_channel_tb
